// ### bench/pin_model.sv
// far side of the timer pins: external clock sources and channel lines
// assumes the block's line outputs win while their enables are high
`timescale 1ns/1ns
`default_nettype none
module pin_model (
  // clock and run control
  input wire logic aclk,
  input wire logic run,
  // block side of the lines
  input wire logic [timer_pkg::NCH-1:0] a_out,
  input wire logic [timer_pkg::NCH-1:0] a_oe,
  input wire logic [timer_pkg::NCH-1:0] b_out,
  input wire logic [timer_pkg::NCH-1:0] b_oe,
  // resolved pin levels
  output logic [timer_pkg::NCH-1:0] ext_in,
  output logic [timer_pkg::NCH-1:0] a_in,
  output logic [timer_pkg::NCH-1:0] b_in
);
  import timer_pkg::*;
  logic [NCH-1:0] ext_lvl = 3'h0;
  logic [NCH-1:0] a_lvl = 3'h0;
  int ext_cnt [NCH];
  int a_cnt [NCH];
  // ------------------------------------------------------------
  // sources: ext pin i half period 5+i cycles, line a 8+i
  // ------------------------------------------------------------
  // frozen while run is low so idle gaps carry no edges
  always @(posedge aclk)
  begin
    for (int i = 0; i < NCH; i++)
    begin
      if (run)
      begin
        ext_cnt[i] <= (ext_cnt[i] >= 4 + i) ? 0 : ext_cnt[i] + 1;
        a_cnt[i] <= (a_cnt[i] >= 7 + i) ? 0 : a_cnt[i] + 1;
        if (ext_cnt[i] >= 4 + i)
          ext_lvl[i] <= ~ext_lvl[i];
        if (a_cnt[i] >= 7 + i)
          a_lvl[i] <= ~a_lvl[i];
      end
    end
  end
  assign ext_in = ext_lvl;
  assign a_in = (a_oe & a_out) | (~a_oe & a_lvl);
  // line b is held low as a steady input unless the block drives it
  assign b_in = b_oe & b_out;
endmodule
`default_nettype wire

// ### bench/tb_timer_block.sv
// self-checking bench for the timer block over axi4-lite
// assumes pin_model on the pins and the checker bound to the block
`timescale 1ns/1ns
`default_nettype none
module tb_timer_block;
  import timer_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic run = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000, rdata, rd, v;
  logic [1:0] bresp, rresp, rs, bs;
  logic awready, wready, bvalid, arready, rvalid, e;
  logic [2:0] ext_in, a_in, a_out, a_oe, b_in, b_out, b_oe;
  logic [1:0] wc [5] = '{2'h1, 2'h3, 2'h0, 2'h2, 2'h3};
  int n_fail = 0, compares = 0, cyc = 0, seed = 5180;
  timer_block uut (
    .aclk(aclk), .aresetn(aresetn), .ce(1'b1),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .ext_clock_input(ext_in), .chan_line_a_in(a_in), .chan_line_a_out(a_out),
    .chan_line_a_oe(a_oe), .chan_line_b_in(b_in), .chan_line_b_out(b_out),
    .chan_line_b_oe(b_oe)
  );
  pin_model pins (
    .aclk(aclk), .run(run), .a_out(a_out), .a_oe(a_oe), .b_out(b_out), .b_oe(b_oe),
    .ext_in(ext_in), .a_in(a_in), .b_in(b_in)
  );
  // ------------------------------------------------------------
  // clock, watchdog, verdict
  // ------------------------------------------------------------
  initial
  begin
    forever #5 aclk = ~aclk;
  end
  task automatic stop_test;
    if (n_fail == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      n_fail++;
      stop_test();
    end
  end
  // ------------------------------------------------------------
  // bus tasks and expectations
  // ------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta;
    logic tw;
    ta = 1'b0;
    tw = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ta && tw))
    begin
      @(posedge aclk);
      if (!ta && awready === 1'b1)
      begin
        ta = 1'b1;
        awvalid <= 1'b0;
      end
      if (!tw && wready === 1'b1)
      begin
        tw = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (bvalid !== 1'b1)
      @(posedge aclk);
    bs = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask
  task automatic chk(input string s, input logic [31:0] x, input logic [31:0] g);
    compares++;
    if (g !== x)
    begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", s, x, g);
    end
  endtask
  task automatic rng(input string s, input int x, input int t, input logic [31:0] g);
    compares++;
    if ($isunknown(g) || g + t < x || g > x + t)
    begin
      n_fail++;
      $display("mismatch %s expected %0d seen %0d", s, x, g);
    end
  endtask
  // counts ticks of channel 0 over a 640-cycle window
  task automatic meas(input logic [31:0] m, input int x, input int t);
    wr(8'h04, m);
    wr(8'h00, 32'h0000_0005);
    repeat (640) @(posedge aclk);
    wr(8'h00, 32'h0000_0002);
    rd_reg(8'h10);
    rng("count", x, t, rd);
  endtask
  task automatic cv_after(input int c);
    repeat (20) @(posedge aclk);
    rd_reg({2'(c), OFF_CV});
  endtask
  // half period of the source a net picks, 0 when routed to nothing
  function automatic int hp(input int n, input int c);
    int t [3][4];
    t = '{'{5, 0, 9, 10}, '{6, 0, 8, 10}, '{7, 0, 8, 9}};
    return t[n][c];
  endfunction
  function automatic logic eff(input logic o, input logic [1:0] c);
    case (c)
      2'b01: return 1'b1;
      2'b10: return 1'b0;
      2'b11: return ~o;
      default: return o;
    endcase
  endfunction
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial
  begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    run <= 1'b1;
    for (int c = 0; c < 3; c++)
    begin
      rd_reg({2'(c), OFF_MODE});
      chk("mode reset", MODE_RST, rd);
      rd_reg({2'(c), OFF_CMD});
      chk("command read", 32'h0000_0000, rd);
    end
    rd_reg(BLK_ROUTE);
    chk("route reset", ROUTE_RST, rd);
    rd_reg(BLK_CMD);
    chk("block read", 32'h0000_0000, rd);
    rd_reg(8'h08);
    chk("unmapped", RESP_SLVERR, rs);
    wr(8'h08, 32'h0000_0001);
    chk("unmapped write", RESP_SLVERR, bs);
    wr(BLK_ROUTE, 32'h0000_0000);
    chk("route write", RESP_OKAY, bs);
    for (int i = 0; i < 6; i++)
    begin
      v = $random(seed) & 32'h000F_47FF;
      wr({2'(i % 3), OFF_MODE}, v);
      rd_reg({2'(i % 3), OFF_MODE});
      chk("mode", v, rd);
      v = $random(seed) & 32'h0000_003F;
      wr(BLK_ROUTE, v);
      rd_reg(BLK_ROUTE);
      chk("route", v, rd);
    end
    for (int c = 0; c < 3; c++)
      wr({2'(c), OFF_MODE}, 32'h0000_0000);
    for (int c = 0; c < 5; c++)
      meas(c, 320 >> (2 * c), 3);
    for (int n = 0; n < 3; n++)
    begin
      for (int c = 0; c < 4; c++)
      begin
        wr(BLK_ROUTE, c << (2 * n));
        meas(5 + n, hp(n, c) > 0 ? 320 / hp(n, c) : 0, 3);
      end
    end
    wr(BLK_ROUTE, 32'h0000_0000);
    meas(32'h0000_000D, 64, 3);
    wr(BLK_ROUTE, 32'h0000_0001);
    meas(32'h0000_0010, 0, 0);
    wr(BLK_ROUTE, 32'h0000_0000);
    meas(32'h0000_0010, 160, 60);
    wr(8'h04, 32'h0000_0000);
    wr(8'h40, 32'h0000_0001);
    repeat (40) @(posedge aclk);
    wr(8'h40, 32'h0000_0002);
    rd_reg(8'h50);
    v = rd;
    rng("enabled run", 22, 6, v);
    cv_after(1);
    chk("disabled", v, rd);
    wr(8'h40, 32'h0000_0003);
    cv_after(1);
    chk("enable with disable", v, rd);
    wr(8'h40, 32'h0000_0004);
    cv_after(1);
    chk("trigger", 32'h0000_0000, rd);
    // trigger too, so counts left over from earlier scenarios are cleared
    for (int c = 0; c < 3; c++)
      wr({2'(c), OFF_CMD}, 32'h0000_0005);
    repeat (30) @(posedge aclk);
    for (int c = 0; c < 3; c++)
      wr({2'(c), OFF_CMD}, 32'h0000_0002);
    wr(BLK_CMD, 32'h0000_0000);
    for (int c = 0; c < 3; c++)
    begin
      cv_after(c);
      rng("held", 30, 29, rd);
    end
    wr(BLK_CMD, 32'h0000_0001);
    for (int c = 0; c < 3; c++)
    begin
      cv_after(c);
      chk("sync", 32'h0000_0000, rd);
    end
    e = 1'b0;
    for (int i = 0; i < 5; i++)
    begin
      wr(8'h84, {wc[i], 6'h00, wc[i], 22'h00_8400});
      wr(8'h80, 32'h0000_0004);
      e = eff(e, wc[i]);
      chk("line a", e, a_out[2]);
      chk("line b", e, b_out[2]);
      chk("enables", 32'h0000_0003, {a_oe[2], b_oe[2]});
    end
    stop_test();
  end
endmodule
`default_nettype wire

// ### bench/timer_block_checker.sv
// assertions on the timer block's bus and pin-direction ports
// assumes ce is held high by the bench; bound to timer_block below
`timescale 1ns/1ns
`default_nettype none
module timer_block_checker (
  // clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // write bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // read bus
  input wire logic [timer_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // pin directions
  input wire logic [timer_pkg::NCH-1:0] chan_line_a_oe,
  input wire logic [timer_pkg::NCH-1:0] chan_line_b_oe
);
  import timer_pkg::*;
  default clocking dc @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // ------------------------------------------------------------
  // bus handshakes
  // ------------------------------------------------------------
  bresp_hold_a:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before bready");
  rdata_hold_a:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before rready");
  read_latency_a:
    assert property (ce && s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  write_latency_a:
    assert property (ce && s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      && !s_axi_bvalid |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  // ------------------------------------------------------------
  // register map and pins
  // ------------------------------------------------------------
  cmd_reads_zero_a:
    assert property (ce && s_axi_arvalid && s_axi_arready && (s_axi_araddr == BLK_CMD
      || s_axi_araddr[5:0] == OFF_CMD && s_axi_araddr[7:6] != 2'b11)
      |=> s_axi_rdata == 32'h0000_0000 && s_axi_rresp == RESP_OKAY)
    else $error("command register read not zero");
  unmapped_read_a:
    assert property (ce && s_axi_arvalid && s_axi_arready && s_axi_araddr[5:0] == 6'h08
      && s_axi_araddr[7:6] != 2'b11 |=> s_axi_rresp == RESP_SLVERR)
    else $error("reserved offset answered okay");
  oe_on_write_a:
    assert property ($past(aresetn) && chan_line_a_oe != $past(chan_line_a_oe)
      |-> $past($rose(s_axi_bvalid)))
    else $error("line a direction changed without a write");
  b_oe_needs_a_a:
    assert property ((chan_line_b_oe & ~chan_line_a_oe) == 3'b000)
    else $error("line b driven outside waveform mode");
  reset_clears_a:
    assert property (disable iff (1'b0) !aresetn && ce |=> !s_axi_bvalid && !s_axi_rvalid
      && chan_line_a_oe == 3'b000 && chan_line_b_oe == 3'b000)
    else $error("outputs not cleared by reset");
  cover property (s_axi_bvalid && s_axi_bready);
  cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
  cover property ($rose(chan_line_b_oe[2]));
endmodule
bind timer_block timer_block_checker chk_i (
  .aclk, .aresetn, .ce, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
  .chan_line_a_oe, .chan_line_b_oe
);
`default_nettype wire

// ### logic/timer_block.sv
// three-channel 16-bit timer: block routing, channel command and mode logic
// assumes an axi4-lite master on aclk; pins are asynchronous and synchronised here
`timescale 1ns/1ns
`default_nettype none
module timer_block (
  // clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // axi4-lite write
  input wire logic [timer_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [timer_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // pins
  input wire logic [timer_pkg::NCH-1:0] ext_clock_input,
  input wire logic [timer_pkg::NCH-1:0] chan_line_a_in,
  output logic [timer_pkg::NCH-1:0] chan_line_a_out,
  output logic [timer_pkg::NCH-1:0] chan_line_a_oe,
  input wire logic [timer_pkg::NCH-1:0] chan_line_b_in,
  output logic [timer_pkg::NCH-1:0] chan_line_b_out,
  output logic [timer_pkg::NCH-1:0] chan_line_b_oe
);
  import timer_pkg::*;

  function automatic logic edge_hit(input logic [1:0] sel, input logic rise,
                                    input logic fall);
    edge_hit = (sel[0] & rise) | (sel[1] & fall);
  endfunction

  function automatic logic apply_fx(input logic cur, input logic [1:0] fx);
    case (fx)
      2'h1: apply_fx = 1'b1;
      2'h2: apply_fx = 1'b0;
      2'h3: apply_fx = ~cur;
      default: apply_fx = cur;
    endcase
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw, input logic [3:0] st);
    for (int k = 0; k < 4; k++)
      merge[8*k +: 8] = st[k] ? nw[8*k +: 8] : old[8*k +: 8];
  endfunction

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    if (a == BLK_CMD || a == BLK_ROUTE)
      mapped = 1'b1;
    else if (a[7:6] < 2'(NCH))
      mapped = a[5:0] == OFF_CMD || a[5:0] == OFF_MODE || a[5:0] == OFF_CV
        || a[5:0] == OFF_RA || a[5:0] == OFF_RB || a[5:0] == OFF_RC;
    else
      mapped = 1'b0;
  endfunction

  // ------------------------------------------------------------
  // axi4-lite write side
  // ------------------------------------------------------------
  logic aw_have;
  logic w_have;
  logic [ADDR_W-1:0] waddr;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  logic wr_go;
  assign wr_go = aw_have & w_have & ~s_axi_bvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn) begin
      aw_have <= 1'b0;
      s_axi_awready <= 1'b0;
      waddr <= '0;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have <= 1'b1;
        s_axi_awready <= 1'b0;
        waddr <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_have <= 1'b0;
        s_axi_awready <= 1'b1;
      end else if (!aw_have) begin
        s_axi_awready <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn) begin
      w_have <= 1'b0;
      s_axi_wready <= 1'b0;
      wdata <= 32'h0000_0000;
      wstrb <= 4'h0;
    end else if (ce) begin
      if (s_axi_wvalid && s_axi_wready) begin
        w_have <= 1'b1;
        s_axi_wready <= 1'b0;
        wdata <= s_axi_wdata;
        wstrb <= s_axi_wstrb;
      end else if (wr_go) begin
        w_have <= 1'b0;
        s_axi_wready <= 1'b1;
      end else if (!w_have) begin
        s_axi_wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (ce) begin
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped(waddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // block registers and pin synchronisers
  // ------------------------------------------------------------
  logic [31:0] route;
  logic sync_pulse;
  logic [3*NCH-1:0] pin_s1;
  logic [3*NCH-1:0] pin_s2;
  logic [3*NCH-1:0] pin_d;
  logic [PRE_W-1:0] pre;
  logic [NCH-1:0] net;
  logic [NCH-1:0] a_lvl;

  // written value is never stored, so it cannot be read back
  assign sync_pulse = wr_go & (waddr == BLK_CMD) & wstrb[0] & wdata[SYNC_BIT];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      route <= ROUTE_RST;
    else if (ce && wr_go && waddr == BLK_ROUTE)
      route <= merge(route, wdata, wstrb);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      pin_d <= '0;
      pre <= '0;
    end else if (ce) begin
      pin_s1 <= {chan_line_b_in, chan_line_a_in, ext_clock_input};
      pin_s2 <= pin_s1;
      pin_d <= pin_s2;
      pre <= pre + 1'b1;
    end
  end

  // ------------------------------------------------------------
  // channels
  // ------------------------------------------------------------
  logic [31:0] mode_v [NCH];
  logic [CNT_W-1:0] cnt_v [NCH];
  logic [CNT_W-1:0] ra_v [NCH];
  logic [CNT_W-1:0] rb_v [NCH];
  logic [CNT_W-1:0] rc_v [NCH];

  for (genvar i = 0; i < NCH; i++)
  begin : g_ch
    localparam int LO = (i == 0) ? 1 : 0;
    localparam int HI = (i == 2) ? 1 : 2;
    logic [31:0] m;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] ra;
    logic [CNT_W-1:0] rb;
    logic [CNT_W-1:0] rc;
    logic ao, aoe, bo, boe;
    logic clk_on, stopped, clk_prev, moved, ev_prev;
    logic wave, wsel, sel_lvl, gate, clk_lvl, tick;
    logic a_rise, a_fall, b_rise, b_fall, s_rise, s_fall;
    logic ev_lvl, ev, ld_a, ld_b, ext_cap;
    logic sw, ext_trig, c_hit, a_hit, b_hit, trig_any, stop_evt, dis_evt;
    logic [1:0] fx_a, fx_b;
    chan_cmd_t cmd;

    // other channels' A level feeds the routing
    assign net[i] = (route[2*i +: 2] == 2'h0) ? pin_s2[i]
                  : (route[2*i +: 2] == 2'h1) ? 1'b0
                  : (route[2*i +: 2] == 2'h2) ? a_lvl[LO] : a_lvl[HI];
    assign a_lvl[i] = aoe ? ao : pin_s2[NCH+i];

    assign wsel = wr_go & (waddr[7:6] == 2'(i));
    assign cmd.on = wsel & (waddr[5:0] == OFF_CMD) & wstrb[0] & wdata[CMD_ON];
    assign cmd.off = wsel & (waddr[5:0] == OFF_CMD) & wstrb[0] & wdata[CMD_OFF];
    assign cmd.trig = wsel & (waddr[5:0] == OFF_CMD) & wstrb[0] & wdata[CMD_TRIG];

    assign wave = m[WAVE_BIT];
    always_comb
    begin
      case (m[CLKSEL_LO +: 3])
        3'h0: sel_lvl = pre[0];
        3'h1: sel_lvl = pre[2];
        3'h2: sel_lvl = pre[4];
        3'h3: sel_lvl = pre[6];
        3'h4: sel_lvl = pre[9];
        3'h5: sel_lvl = net[0];
        3'h6: sel_lvl = net[1];
        default: sel_lvl = net[2];
      endcase
    end
    assign gate = (m[GATE_LO +: 2] == 2'h0) ? 1'b1 : net[m[GATE_LO +: 2] - 2'h1];
    assign clk_lvl = (sel_lvl & gate) ^ m[INV_BIT];
    assign tick = clk_lvl & ~clk_prev & clk_on & ~stopped;

    assign a_rise = pin_s2[NCH+i] & ~pin_d[NCH+i];
    assign a_fall = ~pin_s2[NCH+i] & pin_d[NCH+i];
    assign b_rise = pin_s2[2*NCH+i] & ~pin_d[2*NCH+i];
    assign b_fall = ~pin_s2[2*NCH+i] & pin_d[2*NCH+i];
    assign s_rise = m[SRC_LO] ? a_rise : b_rise;
    assign s_fall = m[SRC_LO] ? a_fall : b_fall;
    assign ld_a = ~wave & edge_hit(m[LDA_LO +: 2], a_rise, a_fall);
    assign ld_b = ~wave & edge_hit(m[LDB_LO +: 2], a_rise, a_fall);
    assign ext_cap = ~wave & edge_hit(m[EDGE_LO +: 2], s_rise, s_fall);

    // event level from B line or a net
    assign ev_lvl = (m[SRC_LO +: 2] == 2'h0) ? pin_s2[2*NCH+i]
                  : net[m[SRC_LO +: 2] - 2'h1];
    assign ev = wave & edge_hit(m[EDGE_LO +: 2], ev_lvl & ~ev_prev, ~ev_lvl & ev_prev);

    // compares fire once, in the cycle after the counter stepped onto the value
    assign c_hit = moved & (cnt == rc);
    assign a_hit = wave & moved & (cnt == ra);
    assign b_hit = wave & moved & (cnt == rb);

    assign sw = cmd.trig | sync_pulse;
    assign ext_trig = ext_cap | (ev & m[EVTRIG_BIT]);
    assign trig_any = sw | ext_trig | (c_hit & m[CTRG_BIT]);
    assign stop_evt = m[STOP_BIT] & (wave ? c_hit : ld_b);
    assign dis_evt = m[DIS_BIT] & (wave ? c_hit : ld_b);

    always_ff @(posedge aclk)
    begin
      if (!aresetn)
        m <= MODE_RST;
      else if (ce && wsel && waddr[5:0] == OFF_MODE)
        m <= merge(m, wdata, wstrb);
    end

    always_ff @(posedge aclk)
    begin
      if (!aresetn) begin
        cnt <= CNT_RST;
        clk_prev <= 1'b0;
        moved <= 1'b0;
        ev_prev <= 1'b0;
      end else if (ce) begin
        clk_prev <= clk_lvl;
        ev_prev <= ev_lvl;
        moved <= tick & ~trig_any;
        if (trig_any)
          cnt <= CNT_RST;
        else if (tick)
          cnt <= cnt + 1'b1;
      end
    end

    always_ff @(posedge aclk)
    begin
      if (!aresetn) begin
        clk_on <= 1'b0;
        stopped <= 1'b0;
      end else if (ce) begin
        if (cmd.off || dis_evt)
          clk_on <= 1'b0;
        else if (cmd.on)
          clk_on <= 1'b1;
        if (trig_any)
          stopped <= 1'b0;
        else if (stop_evt)
          stopped <= 1'b1;
      end
    end

    // capture loads RA and RB in capture mode; software may write those only in waveform mode, RC in any mode
    always_ff @(posedge aclk)
    begin
      if (!aresetn) begin
        ra <= CNT_RST;
        rb <= CNT_RST;
        rc <= CNT_RST;
      end else if (ce) begin
        if (ld_a)
          ra <= cnt;
        else if (wave && wsel && waddr[5:0] == OFF_RA)
          ra <= merge({16'h0000, ra}, wdata, wstrb) [CNT_W-1:0];
        if (ld_b)
          rb <= cnt;
        else if (wave && wsel && waddr[5:0] == OFF_RB)
          rb <= merge({16'h0000, rb}, wdata, wstrb) [CNT_W-1:0];
        if (wsel && waddr[5:0] == OFF_RC)
          rc <= merge({16'h0000, rc}, wdata, wstrb) [CNT_W-1:0];
      end
    end

    // highest-priority event present picks the effect
    assign fx_a = sw ? m[A_SW_LO +: 2] : ev ? m[A_EV_LO +: 2]
                : c_hit ? m[A_MC_LO +: 2] : a_hit ? m[A_MA_LO +: 2] : 2'h0;
    assign fx_b = sw ? m[B_SW_LO +: 2] : ev ? m[B_EV_LO +: 2]
                : c_hit ? m[B_MC_LO +: 2] : b_hit ? m[B_MB_LO +: 2] : 2'h0;

    always_ff @(posedge aclk)
    begin
      if (!aresetn) begin
        ao <= 1'b0;
        bo <= 1'b0;
        aoe <= 1'b0;
        boe <= 1'b0;
      end else if (ce) begin
        aoe <= wave;
        boe <= wave & (m[SRC_LO +: 2] != 2'h0);
        if (wave) begin
          ao <= apply_fx(ao, fx_a);
          bo <= apply_fx(bo, fx_b);
        end
      end
    end

    assign chan_line_a_out[i] = ao;
    assign chan_line_a_oe[i] = aoe;
    assign chan_line_b_out[i] = bo;
    assign chan_line_b_oe[i] = boe;
    assign mode_v[i] = m;
    assign cnt_v[i] = cnt;
    assign ra_v[i] = ra;
    assign rb_v[i] = rb;
    assign rc_v[i] = rc;
  end

  // ------------------------------------------------------------
  // axi4-lite read side
  // ------------------------------------------------------------
  logic [31:0] rd_val;
  logic [1:0] rch;
  logic [5:0] roff;
  assign rch = s_axi_araddr[7:6];
  assign roff = s_axi_araddr[5:0];

  always_comb
  begin
    rd_val = 32'h0000_0000;
    if (s_axi_araddr == BLK_ROUTE)
      rd_val = route;
    else if (rch < 2'(NCH)) begin
      if (roff == OFF_MODE)
        rd_val = mode_v[rch];
      else if (roff == OFF_CV)
        rd_val = {16'h0000, cnt_v[rch]};
      else if (roff == OFF_RA)
        rd_val = {16'h0000, ra_v[rch]};
      else if (roff == OFF_RB)
        rd_val = {16'h0000, rb_v[rch]};
      else if (roff == OFF_RC)
        rd_val = {16'h0000, rc_v[rch]};
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_val;
        s_axi_rresp <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end else if (!s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ### logic/timer_pkg.sv
// constants, register map and field layout of the three-channel timer
// assumes a 32-bit axi4-lite master and a single 100 MHz clock domain
package timer_pkg;
  localparam int NCH = 3;
  localparam int ADDR_W = 8;
  localparam int CNT_W = 16;
  localparam int PRE_W = 10;
  // ------------------------------------------------------------
  // register map (byte addresses)
  // ------------------------------------------------------------
  localparam logic [5:0] OFF_CMD = 6'h00;
  localparam logic [5:0] OFF_MODE = 6'h04;
  localparam logic [5:0] OFF_CV = 6'h10;
  localparam logic [5:0] OFF_RA = 6'h14;
  localparam logic [5:0] OFF_RB = 6'h18;
  localparam logic [5:0] OFF_RC = 6'h1C;
  localparam logic [7:0] BLK_CMD = 8'hC0;
  localparam logic [7:0] BLK_ROUTE = 8'hC4;
  localparam logic [31:0] MODE_RST = 32'h0000_0000;
  localparam logic [31:0] ROUTE_RST = 32'h0000_0000;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int SYNC_BIT = 0;
  localparam int CMD_ON = 0;
  localparam int CMD_OFF = 1;
  localparam int CMD_TRIG = 2;
  localparam int CLKSEL_LO = 0;
  localparam int INV_BIT = 3;
  localparam int GATE_LO = 4;
  localparam int STOP_BIT = 6;
  localparam int DIS_BIT = 7;
  localparam int EDGE_LO = 8;
  localparam int SRC_LO = 10;
  localparam int EVTRIG_BIT = 12;
  localparam int CTRG_BIT = 14;
  localparam int WAVE_BIT = 15;
  localparam int LDA_LO = 16;
  localparam int LDB_LO = 18;
  localparam int A_MA_LO = 16;
  localparam int A_MC_LO = 18;
  localparam int A_EV_LO = 20;
  localparam int A_SW_LO = 22;
  localparam int B_MB_LO = 24;
  localparam int B_MC_LO = 26;
  localparam int B_EV_LO = 28;
  localparam int B_SW_LO = 30;
  typedef struct packed {
    logic trig;
    logic off;
    logic on;
  } chan_cmd_t;
endpackage
